// ==== hw/scp_consts.svh ====
// Offsets, field positions, reset values and masks of the strap and pin block
//
// How it works
// - Fundamental reset clears all non-sticky state
// - Decode two-bit operating mode strap
// - Three-bit strap selects lane split
// - Clock mode strap selects one or two refclks
// - Hot-plug strap low gives pins hot-plug jobs
// - Sample hot-plug strap before fatal output
// - Memory bypass strap read from pin 30
// - Bus select strap: high I2C, low SMBus
// - L1.1 strap low gives pins 15:8 clock requests
// - Expander interrupt starts read that clears it
// - Hot-plug mode drives amber LEDs on 7:0
// - Slot resets follow boot, then hot-plug logic
// - Pin 31 strap: one surprise, zero managed
// - Buffer powerdown low disables buffered clocks
// - Clock request lines open-drain, one per port
// - Source select: high external, low PHY clock
// - Calibrate terminations on reset exit, on request
// - Free pins follow output enable register
`ifndef SCP_CONSTS_SVH
`define SCP_CONSTS_SVH
`define SCP_OFF_CTRL 8'h00
`define SCP_OFF_STRAP 8'h04
`define SCP_OFF_GPIO_OE 8'h08
`define SCP_OFF_GPIO_OUT 8'h0C
`define SCP_OFF_GPIO_IN 8'h10
`define SCP_OFF_LED 8'h14
`define SCP_OFF_STATUS 8'h18
`define SCP_CTRL_CAL_BIT 0
`define SCP_RST_GPIO_OE 32'h0000_0000
`define SCP_RST_GPIO_OUT 32'h0000_0000
`define SCP_RST_LED 8'h00
`define SCP_MASK_STRAP_PINS 32'hC000_0000
`define SCP_MASK_HOTPLUG 32'h04FF_00FF
`define SCP_MASK_L1_1 32'h0000_FF00
`define SCP_POS_PD_PIN 26
`endif

// ==== hw/scp_pkg.sv ====
// Types shared by the strap and pin block
package scp_pkg;
   // Operating modes, in strap code order 00..11
   typedef enum logic [1:0] {
      SCP_OPM_NORMAL,
      SCP_OPM_IDDQ_MBIST,
      SCP_OPM_AC_SCAN,
      SCP_OPM_PHY_TEST
   } scp_op_mode_t;

   // Latched strap set handed to the core
   typedef struct packed {
      scp_op_mode_t op_mode;
      logic [2:0] lane_split;
      logic refclk_split;
      logic smbus_sel;
      logic hotplug_en;
      logic l1_1_en;
      logic surprise_hotplug_strap;
      logic phy_mem_bypass;
   } scp_strap_t;

   // Bus slave phase
   typedef enum logic {
      SCP_BUS_IDLE,
      SCP_BUS_DATA
   } scp_bus_state_t;
endpackage : scp_pkg

// ==== hw/scp_top.sv ====
// Strap latching, shared-pin muxing and AHB-Lite registers
//
// The AHB-Lite slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "scp_consts.svh"
module scp_top
   import scp_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Board straps and dedicated pins
   input wire logic fundamental_reset_n,
   input wire logic [1:0] chip_op_mode_strap,
   input wire logic [2:0] lane_split_strap,
   input wire logic refclk_mode_strap,
   input wire logic mgmt_bus_select_strap,
   input wire logic clock_buffer_source_select,
   input wire logic hotplug_expander_irq_n,
   // Shared fatal error / hot-plug strap pin
   input wire logic fatal_pin_in,
   output logic fatal_pin_out,
   output logic fatal_pin_oe_n,
   // Shared interrupt / L1.1 strap pin, open drain
   input wire logic irq_pin_in,
   output logic irq_pin_out,
   output logic irq_pin_oe_n,
   // General-purpose pins
   input wire logic [31:0] gpio_in,
   output logic [31:0] gpio_out,
   output logic [31:0] gpio_oe_n,
   // Core side
   input wire logic fatal_error,
   input wire logic core_irq,
   input wire logic [7:0] hp_slot_reset_n,
   input wire logic [7:0] port_clock_request,
   input wire logic hp_read_done,
   output logic hp_read_req,
   output scp_strap_t strap,
   output logic core_reset_n,
   output logic clock_buffer_on,
   output logic clock_buffer_from_ext,
   output logic term_cal_start,
   output logic [7:0] port_clock_request_seen
);

   // Two-flop synchroniser for every pin input
   localparam int SW = 44;
   logic [SW-1:0] sync1_q;
   logic [SW-1:0] sync2_q;
   wire [SW-1:0] async_in = {fundamental_reset_n, chip_op_mode_strap,
      lane_split_strap, refclk_mode_strap, mgmt_bus_select_strap,
      clock_buffer_source_select, hotplug_expander_irq_n,
      fatal_pin_in, irq_pin_in, gpio_in};

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         sync1_q <= '0;
         sync2_q <= '0;
      end else begin
         sync1_q <= async_in;
         sync2_q <= sync1_q;
      end
   end

   // Synchronised fields
   wire s_fund_rst_n = sync2_q[43];
   wire [1:0] s_opmode = sync2_q[42:41];
   wire [2:0] s_lanes = sync2_q[40:38];
   wire s_refclk_mode = sync2_q[37];
   wire s_mgmt = sync2_q[36];
   wire s_srcsel = sync2_q[35];
   wire s_expirq_n = sync2_q[34];
   wire s_fatal_pin = sync2_q[33];
   wire s_irq_pin = sync2_q[32];
   wire [31:0] s_gpio = sync2_q[31:0];

   // Boot phase: fundamental reset held
   wire boot = !s_fund_rst_n;
   logic boot_q;
   wire release_edge = boot_q && !boot;

   // Live strap decode while sampling
   scp_strap_t strap_live;
   assign strap_live.op_mode = scp_op_mode_t'(s_opmode);
   assign strap_live.lane_split = s_lanes;
   assign strap_live.refclk_split = s_refclk_mode;
   assign strap_live.smbus_sel = !s_mgmt;
   assign strap_live.hotplug_en = !s_fatal_pin;
   assign strap_live.l1_1_en = !s_irq_pin;
   assign strap_live.surprise_hotplug_strap = s_gpio[31];
   assign strap_live.phy_mem_bypass = s_gpio[30];

   // Keep sampling through reset, freeze at release
   scp_strap_t strap_d;
   scp_strap_t strap_q;
   assign strap_d = boot ? strap_live : strap_q;

   // Bus address phase decode
   logic [7:0] addr_q;
   logic wr_q;
   scp_bus_state_t bus_q;
   wire take = hsel && htrans[1] && hready;
   wire in_data = (bus_q == SCP_BUS_DATA);
   wire do_wr = in_data && wr_q;
   wire wr_ctrl = do_wr && (addr_q == `SCP_OFF_CTRL);
   wire wr_oe = do_wr && (addr_q == `SCP_OFF_GPIO_OE);
   wire wr_out = do_wr && (addr_q == `SCP_OFF_GPIO_OUT);
   wire wr_led = do_wr && (addr_q == `SCP_OFF_LED);

   // Software registers
   logic [31:0] gpio_oe_q;
   logic [31:0] gpio_out_q;
   logic [7:0] led_q;
   logic exp_pend_q;

   // Strap-selected pin functions
   wire hp_fn = boot ? strap_live.hotplug_en : strap_q.hotplug_en;
   wire l1_fn = boot ? strap_live.l1_1_en : strap_q.l1_1_en;
   wire [31:0] own = (hp_fn ? `SCP_MASK_HOTPLUG : 32'h0000_0000)
      | (l1_fn ? `SCP_MASK_L1_1 : 32'h0000_0000);
   wire [31:0] samp = boot ? `SCP_MASK_STRAP_PINS : 32'h0000_0000;

   // Slot resets held low while booting
   wire [7:0] slot_rst_n = boot ? 8'h00 : hp_slot_reset_n;

   // Function outputs and enables, enable active low
   wire [31:0] fn_out = {8'h00, slot_rst_n, 8'h00, led_q};
   wire [31:0] fn_oe_n = {5'h00, 1'b1, 2'h0, 8'h00,
      ~port_clock_request, 8'h00};

   // Strap pins released first, then functions, then GPIO
   wire [31:0] gpio_oe_n_d = samp
      | (~samp & own & fn_oe_n)
      | (~samp & ~own & ~gpio_oe_q);
   wire [31:0] gpio_out_d = (own & fn_out)
      | (~own & gpio_out_q);

   // Shared single pins: released while sampling
   wire fatal_oe_n_d = boot;
   wire fatal_out_d = !fatal_error;
   wire irq_oe_n_d = boot || !core_irq;

   // Clock buffer: powerdown pin only in hot-plug pin map
   wire pd_pin = s_gpio[`SCP_POS_PD_PIN];
   wire buf_on_d = !(hp_fn && !pd_pin);

   // Expander interrupt: a new assertion beats the done clear
   wire exp_d = !s_expirq_n || (exp_pend_q && !hp_read_done);

   // Calibration on reset exit or software request
   wire cal_d = release_edge
      || (wr_ctrl && hwdata[`SCP_CTRL_CAL_BIT]);

   // Read word selects, one per mapped offset except CTRL, which has none and reads zero
   wire rs_strap = (addr_q == `SCP_OFF_STRAP);
   wire rs_oe = (addr_q == `SCP_OFF_GPIO_OE);
   wire rs_out = (addr_q == `SCP_OFF_GPIO_OUT);
   wire rs_in = (addr_q == `SCP_OFF_GPIO_IN);
   wire rs_led = (addr_q == `SCP_OFF_LED);
   wire rs_status = (addr_q == `SCP_OFF_STATUS);

   // Read words, unused high bits zero
   wire [31:0] rw_strap = {21'h00_0000, strap_q};
   wire [31:0] rw_led = {24'h00_0000, led_q};
   wire [31:0] rw_status = {14'h0000, boot, buf_on_d,
      s_gpio[15:8], 7'h00, exp_pend_q};

   // Read mux; unmapped offsets read zero
   logic [31:0] rd_mux;
   assign rd_mux =
      rs_strap ? rw_strap :
      rs_oe ? gpio_oe_q :
      rs_out ? gpio_out_q :
      rs_in ? s_gpio :
      rs_led ? rw_led :
      rs_status ? rw_status :
      32'h0000_0000;

   // Bus slave: one wait state so read data comes from a flop
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         bus_q <= SCP_BUS_IDLE;
         addr_q <= 8'h00;
         wr_q <= 1'b0;
         hreadyout <= 1'b1;
         hrdata <= 32'h0000_0000;
      end else if (take && !in_data) begin
         bus_q <= SCP_BUS_DATA;
         addr_q <= haddr[7:0];
         wr_q <= hwrite;
         hreadyout <= 1'b0;
      end else if (in_data) begin
         bus_q <= SCP_BUS_IDLE;
         hreadyout <= 1'b1;
         hrdata <= wr_q ? 32'h0000_0000 : rd_mux;
      end
   end

   // Responses are always OKAY
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         hresp <= 1'b0;
      end else begin
         hresp <= 1'b0;
      end
   end

   // Sticky GPIO setup survives the fundamental reset
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         gpio_oe_q <= `SCP_RST_GPIO_OE;
         gpio_out_q <= `SCP_RST_GPIO_OUT;
      end else begin
         if (wr_oe) begin
            gpio_oe_q <= hwdata;
         end
         if (wr_out) begin
            gpio_out_q <= hwdata;
         end
      end
   end

   // Non-sticky state cleared while the fundamental reset is held
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         led_q <= `SCP_RST_LED;
         exp_pend_q <= 1'b0;
         term_cal_start <= 1'b0;
      end else if (boot) begin
         led_q <= `SCP_RST_LED;
         exp_pend_q <= 1'b0;
         term_cal_start <= 1'b0;
      end else begin
         if (wr_led) begin
            led_q <= hwdata[7:0];
         end
         exp_pend_q <= exp_d;
         term_cal_start <= cal_d;
      end
   end

   // Strap latch and reset tracking
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         boot_q <= 1'b1;
         strap_q <= '0;
         strap <= '0;
         core_reset_n <= 1'b0;
      end else begin
         boot_q <= boot;
         strap_q <= strap_d;
         strap <= strap_d;
         core_reset_n <= !boot;
      end
   end

   // Registered pin outputs; all released under reset
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         gpio_out <= 32'h0000_0000;
         gpio_oe_n <= 32'hFFFF_FFFF;
         fatal_pin_out <= 1'b1;
         fatal_pin_oe_n <= 1'b1;
         irq_pin_out <= 1'b0;
         irq_pin_oe_n <= 1'b1;
      end else begin
         gpio_out <= gpio_out_d;
         gpio_oe_n <= gpio_oe_n_d;
         fatal_pin_out <= fatal_out_d;
         fatal_pin_oe_n <= fatal_oe_n_d;
         irq_pin_out <= 1'b0;
         irq_pin_oe_n <= irq_oe_n_d;
      end
   end

   // Core-facing status flops
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         hp_read_req <= 1'b0;
         clock_buffer_on <= 1'b1;
         clock_buffer_from_ext <= 1'b0;
         port_clock_request_seen <= 8'h00;
      end else begin
         hp_read_req <= exp_d && !boot;
         clock_buffer_on <= buf_on_d;
         clock_buffer_from_ext <= s_srcsel;
         port_clock_request_seen <= l1_fn ? ~s_gpio[15:8] : 8'h00;
      end
   end

endmodule : scp_top
`default_nettype wire

// ==== verif/scp_top_sva.sv ====
// Checker on the strap and shared-pin block ports
`timescale 1ns/1ps
`default_nettype none
module scp_top_sva
   import scp_pkg::*;
(
   // Clock and resets
   input wire logic mclk,
   input wire logic resetn,
   input wire logic fundamental_reset_n,
   // Pins and core side
   input wire logic fatal_pin_oe_n,
   input wire logic irq_pin_oe_n,
   input wire logic [31:0] gpio_in,
   input wire logic [31:0] gpio_out,
   input wire logic [31:0] gpio_oe_n,
   input wire logic [7:0] hp_slot_reset_n,
   input wire logic [7:0] port_clock_request,
   input wire scp_strap_t strap,
   input wire logic core_reset_n,
   input wire logic clock_buffer_on,
   input wire logic term_cal_start
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);
   // Pin muxes are checked past boot once registered pins settle: LEDs one edge after, slot resets and clock requests two
   a_core_reset: assert property ((!fundamental_reset_n) [*5] |-> !core_reset_n)
      else $error("core reset not held");
   a_strap_hold: assert property (core_reset_n && $past(core_reset_n) && $past(core_reset_n, 2) |-> $stable(strap))
      else $error("strap changed after boot");
   a_boot_release: assert property (!core_reset_n && !$past(core_reset_n) |->
      fatal_pin_oe_n && irq_pin_oe_n && (gpio_oe_n[31:30] == 2'h3))
      else $error("strap pin driven in boot");
   a_cal_on_exit: assert property ($rose(core_reset_n) |-> ##[0:2] term_cal_start)
      else $error("no calibration on boot exit");
   a_cal_pulse: assert property (term_cal_start |=> !term_cal_start)
      else $error("calibration pulse too long");
   a_led_drive: assert property (strap.hotplug_en && core_reset_n && $past(core_reset_n) |->
      gpio_oe_n[7:0] == 8'h00)
      else $error("led pins not driven");
   a_slot_reset: assert property (strap.hotplug_en && core_reset_n && $past(core_reset_n, 2) |->
      gpio_out[23:16] == $past(hp_slot_reset_n))
      else $error("slot reset mismatch");
   a_clkreq_drive: assert property (strap.l1_1_en && core_reset_n && $past(core_reset_n, 2) |->
      gpio_oe_n[15:8] == ~$past(port_clock_request) && gpio_out[15:8] == 8'h00)
      else $error("clock request mismatch");
   a_buf_powerdown: assert property ((strap.hotplug_en && core_reset_n && !gpio_in[26]) [*5] |->
      !clock_buffer_on)
      else $error("buffer not powered down");
endmodule : scp_top_sva
`default_nettype wire

// ==== verif/scp_board.sv ====
// Board model: strap resistors, pin wiring, hot-plug expander
`timescale 1ns/1ps
`default_nettype none
module scp_board (
   // Clock and bench commands
   input wire logic mclk,
   input wire logic hp_strap_n,
   input wire logic [31:0] gpio_pull,
   input wire logic irq_cmd,
   input wire logic l1_strap_n,
   // Device pins
   input wire logic fatal_pin_out,
   input wire logic fatal_pin_oe_n,
   input wire logic irq_pin_out,
   input wire logic irq_pin_oe_n,
   input wire logic [31:0] gpio_out,
   input wire logic [31:0] gpio_oe_n,
   input wire logic hp_read_done,
   output logic fatal_pin_in,
   output logic irq_pin_in,
   output logic [31:0] gpio_in,
   output logic hotplug_expander_irq_n
);
   // Released pins fall to the board resistor level
   assign fatal_pin_in = fatal_pin_oe_n ? hp_strap_n : fatal_pin_out;
   assign irq_pin_in = irq_pin_oe_n ? l1_strap_n : irq_pin_out;
   assign gpio_in = (gpio_oe_n & gpio_pull) | (~gpio_oe_n & gpio_out);
   // Status change raises the interrupt, a finished read clears it
   logic irq_n_q = 1'b1;
   assign hotplug_expander_irq_n = irq_n_q;
   always @(posedge mclk) begin
      if (irq_cmd) irq_n_q <= 1'b0;
      else if (hp_read_done) irq_n_q <= 1'b1;
   end
endmodule : scp_board
`default_nettype wire

// ==== verif/strap_and_shared_pin_control_tb.sv ====
// Bench for strap latching and shared-pin control
`timescale 1ns/1ps
`default_nettype none
module strap_and_shared_pin_control_tb;
   import scp_pkg::*;
   logic mclk, resetn, hsel, hwrite, hreadyout, hresp, fundamental_reset_n, refclk_mode_strap;
   logic mgmt_bus_select_strap, clock_buffer_source_select, hotplug_expander_irq_n, fatal_pin_in;
   logic fatal_pin_out, fatal_pin_oe_n, irq_pin_out, irq_pin_oe_n, fatal_error, core_irq, hp_strap_n;
   logic hp_read_done, hp_read_req, core_reset_n, clock_buffer_on, clock_buffer_from_ext, term_cal_start;
   logic irq_cmd, irq_pin_in, l1_strap_n;
   logic [1:0] htrans, chip_op_mode_strap;
   logic [2:0] lane_split_strap;
   logic [7:0] hp_slot_reset_n, port_clock_request, port_clock_request_seen;
   logic [31:0] haddr, hwdata, hrdata, gpio_in, gpio_out, gpio_oe_n, gpio_pull, rd;
   scp_strap_t strap, exp_s;
   int error_cnt, checks, cyc, cal_cnt;
   // Device and its board, strap resistors set by the bench
   scp_top dut_u (.mclk, .resetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
      .hready(hreadyout), .hreadyout, .hresp, .hrdata, .fundamental_reset_n, .chip_op_mode_strap,
      .lane_split_strap, .refclk_mode_strap, .mgmt_bus_select_strap, .clock_buffer_source_select,
      .hotplug_expander_irq_n, .fatal_pin_in, .fatal_pin_out, .fatal_pin_oe_n, .irq_pin_in,
      .irq_pin_out, .irq_pin_oe_n, .gpio_in, .gpio_out, .gpio_oe_n, .fatal_error, .core_irq,
      .hp_slot_reset_n, .port_clock_request, .hp_read_done, .hp_read_req, .strap, .core_reset_n,
      .clock_buffer_on, .clock_buffer_from_ext, .term_cal_start, .port_clock_request_seen);
   scp_board brd_u (.mclk, .hp_strap_n, .gpio_pull, .irq_cmd, .l1_strap_n, .fatal_pin_out, .fatal_pin_oe_n,
      .irq_pin_out, .irq_pin_oe_n, .gpio_out, .gpio_oe_n, .hp_read_done, .fatal_pin_in, .irq_pin_in,
      .gpio_in, .hotplug_expander_irq_n);
   // 40 MHz clock
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   // Hang guard and calibration pulse count
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (term_cal_start === 1'b1) cal_cnt <= cal_cnt + 1;
      if (cyc == 20000) begin
         error_cnt++;
         results();
      end
   end
   task automatic results();
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : results
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic wt(input int n);
      repeat (n) @(posedge mclk);
   endtask : wt
   // One AHB-Lite single word transfer, waits on hready in both phases
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : bus
   // Fundamental reset pulse with new strap levels
   task automatic boot(input logic [1:0] c);
      fundamental_reset_n <= 1'b0;
      chip_op_mode_strap <= c;
      refclk_mode_strap <= c[0];
      mgmt_bus_select_strap <= c[1];
      hp_strap_n <= (c == 2'h1);
      l1_strap_n <= (c == 2'h2);
      wt(8);
      chk({gpio_oe_n[23:16], gpio_out[23:16]}, (c == 2'h1) ? 32'h0000_FF00 : 32'h0);
      fundamental_reset_n <= 1'b1;
      wt(8);
      exp_s = {c, 3'h5, c[0], ~c[1], c != 2'h1, c != 2'h2, 2'h2};
   endtask : boot
   initial begin
      resetn = 1'b0;
      fundamental_reset_n = 1'b0;
      {hsel, hwrite, htrans, haddr, hwdata, chip_op_mode_strap} = '0;
      {refclk_mode_strap, mgmt_bus_select_strap, clock_buffer_source_select} = '0;
      lane_split_strap = 3'h5;
      {fatal_error, core_irq, hp_read_done, irq_cmd, hp_strap_n, l1_strap_n} = '0;
      hp_slot_reset_n = 8'hFF;
      port_clock_request = 8'h00;
      gpio_pull = 32'hBFFF_FFFF;
      wt(20);
      resetn <= 1'b1;
      // Every mode code, both clock modes, both bus protocols
      for (int c = 0; c < 4; c++) begin
         boot(c[1:0]);
         chk(strap, exp_s);
      end
      chk(cal_cnt, 4);
      bus(8'h04, 1'b0, 32'h0);
      chk(rd, exp_s);
      chip_op_mode_strap <= 2'h1;
      gpio_pull[31] <= 1'b0;
      fatal_error <= 1'b1;
      core_irq <= 1'b1;
      wt(8);
      chk(strap, exp_s);
      chk({fatal_pin_in, irq_pin_oe_n}, 2'h0);
      bus(8'h14, 1'b1, 32'hA5);
      hp_slot_reset_n <= 8'h3C;
      port_clock_request <= 8'h81;
      gpio_pull[26] <= 1'b0;
      clock_buffer_source_select <= 1'b1;
      wt(8);
      chk(gpio_out[7:0], 8'hA5);
      chk(gpio_out[23:16], 8'h3C);
      chk({gpio_in[15:8], port_clock_request_seen}, 16'h7E81);
      chk({clock_buffer_on, clock_buffer_from_ext}, 2'h1);
      gpio_pull[26] <= 1'b1;
      clock_buffer_source_select <= 1'b0;
      irq_cmd <= 1'b1;
      wt(1);
      irq_cmd <= 1'b0;
      while (hp_read_req !== 1'b1) wt(1);
      chk({clock_buffer_on, clock_buffer_from_ext}, 2'h2);
      bus(8'h18, 1'b0, 32'h0);
      chk(rd, 32'h0001_7E01);
      // A read done while the line is still low is ignored, so read twice
      repeat (2) begin
         hp_read_done <= 1'b1;
         wt(1);
         hp_read_done <= 1'b0;
         wt(5);
      end
      chk({hp_read_req, hotplug_expander_irq_n}, 2'h1);
      bus(8'h00, 1'b1, 32'h1);
      wt(3);
      chk(cal_cnt, 5);
      bus(8'h08, 1'b1, 32'h2A00_0000);
      bus(8'h0C, 1'b1, 32'h2800_0000);
      bus(8'h40, 1'b1, 32'hFFFF_FFFF);
      wt(2);
      chk(gpio_oe_n & 32'h3B00_0000, 32'h1100_0000);
      chk(gpio_out & 32'h2A00_0000, 32'h2800_0000);
      bus(8'h40, 1'b0, 32'h0);
      chk(rd, 32'h0);
      chk(hresp, 32'h0);
      // Another boot keeps the sticky OE register, clears LEDs
      boot(2'h0);
      bus(8'h08, 1'b0, 32'h0);
      chk(rd, 32'h2A00_0000);
      bus(8'h14, 1'b0, 32'h0);
      chk(rd, 32'h0);
      results();
   end
endmodule : strap_and_shared_pin_control_tb
bind scp_top scp_top_sva chk_u (.mclk, .resetn, .fundamental_reset_n, .fatal_pin_oe_n, .irq_pin_oe_n,
   .gpio_in, .gpio_out, .gpio_oe_n, .hp_slot_reset_n, .port_clock_request, .strap, .core_reset_n,
   .clock_buffer_on, .term_cal_start);
`default_nettype wire
